// [design/tpd_pkg.sv]
// Shared constants and types for the panel timing driver.
// Assumes one 20 MHz reference clock and an RGB565 pixel source.
package tpd_pkg;

  // Clock rates in Hz
  localparam int REF_CLK_HZ = 20000000;
  localparam int PIX_CLK_HZ = 2500000;

  // Pixel clock divider, half-duty
  localparam int PCLK_DIV_CYC = REF_CLK_HZ / PIX_CLK_HZ;
  localparam int PCLK_HIGH_CYC = PCLK_DIV_CYC / 2;
  localparam int DIV_W = 4;

  // Frame geometry in pixel clocks and lines
  localparam int FRAME_HZ = 60;
  localparam int FRAME_HZ_MIN = 50;
  localparam int FRAME_HZ_MAX = 80;
  localparam int H_ACTIVE = 320;
  localparam int V_ACTIVE = 96;
  localparam int V_BLANK = 10;
  localparam int V_TOTAL = V_ACTIVE + V_BLANK;
  localparam int H_TOTAL = PIX_CLK_HZ / (FRAME_HZ * V_TOTAL);
  localparam int H_SYNC_PCLK = 8;
  localparam int H_BACK_PCLK = 32;
  localparam int H_START = H_SYNC_PCLK + H_BACK_PCLK;
  localparam int V_SYNC_LINES = 1;
  localparam int HCNT_W = 9;
  localparam int VCNT_W = 7;

  // Buffer in the pixel path
  localparam int BUF_DEPTH = 2;

  typedef struct packed {
    logic [4:0] red;
    logic [5:0] green;
    logic [4:0] blue;
  } tpd_rgb565_t;

  localparam int PIX_W = $bits(tpd_rgb565_t);

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } tpd_bytes_t;

  typedef struct packed {
    logic [5:0] red;
    logic [5:0] green;
    logic [5:0] blue;
  } tpd_rgb666_t;

  // Panel side wiring: lowest red and blue copy the next bit up
  function automatic tpd_rgb666_t tpd_expand18(input tpd_rgb565_t w);
    tpd_rgb666_t p;
    p.red = {w.red, w.red[0]};
    p.green = w.green;
    p.blue = {w.blue, w.blue[0]};
    return p;
  endfunction

endpackage

// [design/tpd_pix_buf.sv]
// Small valid/ready buffer that sits in the pixel word path.
// Assumes both sides run on ref_clk; out_data is valid while out_valid.
`timescale 1ns/10ps
module tpd_pix_buf
  import tpd_pkg::*;
#(
  parameter int W = PIX_W,
  parameter int DEPTH = BUF_DEPTH
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic in_rdy;
  } tpd_buf_state_t;

  tpd_buf_state_t s_reg;
  tpd_buf_state_t s_next;
  logic push;
  logic pop;

  always_comb
  begin
    s_next = s_reg;
    push = in_valid && s_reg.in_rdy;
    pop = out_ready && (s_reg.count != '0);
    if (push)
    begin
      s_next.mem[s_reg.wr_ptr] = in_data;
      s_next.wr_ptr = (s_reg.wr_ptr == PTR_LAST) ? '0
                      : s_reg.wr_ptr + 1'b1;
    end
    if (pop)
    begin
      s_next.rd_ptr = (s_reg.rd_ptr == PTR_LAST) ? '0
                      : s_reg.rd_ptr + 1'b1;
    end
    case ({push, pop})
      2'b10: s_next.count = s_reg.count + 1'b1;
      2'b01: s_next.count = s_reg.count - 1'b1;
      default: s_next.count = s_reg.count;
    endcase
    // Registered ready keeps the source path free of combinational loops
    s_next.in_rdy = (s_next.count != CNT_FULL);
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s_reg <= '0;
      s_reg.in_rdy <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign in_ready = s_reg.in_rdy;
  assign out_data = s_reg.mem[s_reg.rd_ptr];
  assign out_valid = (s_reg.count != '0);

endmodule

// [design/tpd_panel_drv.sv]
// Timing and data driver for a parallel RGB TFT panel.
// Assumes a pixel word source on ref_clk with valid/ready handshake;
// all panel outputs are one-way and registered.
//
// Operation
// - Each pixel is one 16-bit word, all bits updated together.
// - Words are 5-6-5; panel ties lowest red and blue to next bit.
// - Pixel clock runs at 2.5 MHz, above raw pixel rate.
// - Pixel clock divides the system clock at half duty.
// - Pixel clock free-runs; data advances at every falling edge.
// - Falling edges are found by sampling our own pixel clock output.
// - Data enable is active only while a valid pixel is driven.
// - Horizontal sync marks the start of every line.
// - Vertical sync marks the start of every frame.
// - Every panel signal is an output; nothing returns from the panel.
// - Frames repeat between 50 and 80 times a second.
// - Active frame is 320 pixels by 96 lines at 60 Hz.
// - No pixel data and no data enable during blanking.
// - Pixels go out in one unbroken burst per line; a starved slot breaks it with enable low.
// - Syncs are plain levels changed at their own points.
// - Ten blanking lines plus 96 active, 106 lines per frame.
// - First ten lines of a frame are blanking; only the first carries vertical sync.
// - Each active line carries exactly 320 pixel words; a starved slot carries none.
`timescale 1ns/10ps
module tpd_panel_drv
  import tpd_pkg::*;
#(
  parameter int CLK_HZ = REF_CLK_HZ,
  parameter int PIX_HZ = PIX_CLK_HZ,
  parameter int H_ACT = H_ACTIVE,
  parameter int V_ACT = V_ACTIVE,
  parameter int V_BLK = V_BLANK,
  parameter int H_SYNC = H_SYNC_PCLK,
  parameter int H_BACK = H_BACK_PCLK,
  parameter int V_SYNC = V_SYNC_LINES
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire tpd_rgb565_t pix_in_data,
  input wire logic pix_in_valid,
  output logic pix_in_ready,
  output logic [7:0] pixel_out_port_a,
  output logic [7:0] pixel_out_port_b,
  output logic pclk,
  output logic de,
  output logic hsync_n,
  output logic vsync_n,
  output logic frame_start,
  output logic underrun
);

  // Derived timing, in ref_clk cycles, pixel clocks or lines
  localparam int DIV_CYC = CLK_HZ / PIX_HZ;
  localparam int HALF_CYC = DIV_CYC / 2;
  localparam int V_TOT = V_ACT + V_BLK;
  localparam int H_TOT = PIX_HZ / (FRAME_HZ * V_TOT);
  localparam int H_FIRST = H_SYNC + H_BACK;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV_CYC - 1);
  localparam logic [DIV_W-1:0] DIV_HIGH = DIV_W'(HALF_CYC);
  localparam logic [HCNT_W-1:0] H_LAST = HCNT_W'(H_TOT - 1);
  localparam logic [HCNT_W-1:0] H_SYNC_END = HCNT_W'(H_SYNC);
  localparam logic [HCNT_W-1:0] H_ACT_FIRST = HCNT_W'(H_FIRST);
  localparam logic [HCNT_W-1:0] H_ACT_END = HCNT_W'(H_FIRST + H_ACT);
  localparam logic [VCNT_W-1:0] V_LAST = VCNT_W'(V_TOT - 1);
  localparam logic [VCNT_W-1:0] V_ACT_FIRST = VCNT_W'(V_BLK);
  localparam logic [VCNT_W-1:0] V_SYNC_END = VCNT_W'(V_SYNC);

  // Line must fit sync, porch and pixels; frame rate must stay in range
  localparam int FRAME_RATE = PIX_HZ / (H_TOT * V_TOT);
  localparam bit GEOM_OK = (H_TOT > H_FIRST + H_ACT)
                           && (FRAME_RATE >= FRAME_HZ_MIN)
                           && (FRAME_RATE <= FRAME_HZ_MAX)
                           && (V_SYNC <= V_BLK)
                           && (DIV_CYC >= 2);

  typedef enum logic [1:0] {
    TPD_SYNC,
    TPD_PORCH,
    TPD_ACTIVE,
    TPD_TAIL
  } tpd_hphase_t;

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic pclk;
    logic pclk_seen;
    logic [HCNT_W-1:0] hcnt;
    logic [VCNT_W-1:0] vcnt;
    tpd_hphase_t hphase;
    tpd_rgb565_t pix;
    logic de;
    logic hsync_n;
    logic vsync_n;
    logic frame_start;
    logic underrun;
    logic started;
  } tpd_state_t;

  tpd_state_t s_reg;
  tpd_state_t s_next;
  tpd_bytes_t pix_bytes;
  tpd_rgb565_t buf_data;
  logic buf_valid;
  logic buf_pop;
  logic fall;
  logic [HCNT_W-1:0] h_n;
  logic [VCNT_W-1:0] v_n;
  logic line_active;
  logic slot_active;

  // Two-entry buffer lets the source stall without losing a word
  tpd_pix_buf #(
    .W(PIX_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_data(pix_in_data),
    .in_valid(pix_in_valid),
    .in_ready(pix_in_ready),
    .out_data(buf_data),
    .out_valid(buf_valid),
    .out_ready(buf_pop)
  );

  always_comb
  begin
    s_next = s_reg;
    s_next.frame_start = 1'b0;
    buf_pop = 1'b0;
    h_n = s_reg.hcnt;
    v_n = s_reg.vcnt;
    line_active = 1'b0;
    slot_active = 1'b0;

    // Free-running half-duty divider, never gated
    if (s_reg.div == DIV_LAST)
    begin
      s_next.div = '0;
    end
    else
    begin
      s_next.div = s_reg.div + 1'b1;
    end
    s_next.pclk = (s_next.div < DIV_HIGH);

    // Edge found from our own output, one ref_clk after it falls;
    // data then changes well inside the low half of the pixel clock
    s_next.pclk_seen = s_reg.pclk;
    fall = s_reg.pclk_seen && !s_reg.pclk;

    if (fall)
    begin
      // Line counter advances once per pixel clock, frame counter once per line
      if (s_reg.hcnt == H_LAST)
      begin
        h_n = '0;
        if (s_reg.vcnt == V_LAST)
        begin
          v_n = '0;
        end
        else
        begin
          v_n = s_reg.vcnt + 1'b1;
        end
      end
      else
      begin
        h_n = s_reg.hcnt + 1'b1;
      end
      s_next.hcnt = h_n;
      s_next.vcnt = v_n;

      // Horizontal phase of the new position
      if (h_n < H_SYNC_END)
      begin
        s_next.hphase = TPD_SYNC;
      end
      else if (h_n < H_ACT_FIRST)
      begin
        s_next.hphase = TPD_PORCH;
      end
      else if (h_n < H_ACT_END)
      begin
        s_next.hphase = TPD_ACTIVE;
      end
      else
      begin
        s_next.hphase = TPD_TAIL;
      end

      // Blanking lines come first, then the active lines
      line_active = (v_n >= V_ACT_FIRST);
      slot_active = line_active && (s_next.hphase == TPD_ACTIVE);

      // Syncs are independent levels; hsync on every line
      s_next.hsync_n = !(h_n < H_SYNC_END);
      s_next.vsync_n = !(v_n < V_SYNC_END);
      s_next.frame_start = (h_n == '0) && (v_n == '0);
      if (s_next.frame_start)
      begin
        s_next.started = 1'b1;
      end

      case (s_next.hphase)
        TPD_ACTIVE:
        begin
          if (slot_active && buf_valid)
          begin
            // One whole 16-bit word per pixel clock
            s_next.pix = buf_data;
            s_next.de = 1'b1;
            buf_pop = 1'b1;
          end
          else if (slot_active)
          begin
            // Starved slot: hold enable off, keep the line length
            s_next.pix = '0;
            s_next.de = 1'b0;
            s_next.underrun = 1'b1;
          end
          else
          begin
            s_next.pix = '0;
            s_next.de = 1'b0;
          end
        end
        TPD_SYNC, TPD_PORCH, TPD_TAIL:
        begin
          s_next.pix = '0;
          s_next.de = 1'b0;
        end
        default:
        begin
          s_next.pix = '0;
          s_next.de = 1'b0;
        end
      endcase

      // Sticky underrun clears at frame start; a new miss still wins
      if (s_next.frame_start && !(slot_active && !buf_valid))
      begin
        s_next.underrun = 1'b0;
      end
    end

    // Partial frame after reset would give short syncs; keep it dark
    if (!s_next.started)
    begin
      s_next.pix = '0;
      s_next.de = 1'b0;
      s_next.hsync_n = 1'b1;
      s_next.vsync_n = 1'b1;
      s_next.underrun = 1'b0;
      buf_pop = 1'b0;
    end

    // A geometry that breaks the line or rate limits stays blank
    if (!GEOM_OK)
    begin
      s_next.de = 1'b0;
      s_next.pix = '0;
      buf_pop = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s_reg <= '0;
      s_reg.hphase <= TPD_SYNC;
      s_reg.hsync_n <= 1'b1;
      s_reg.vsync_n <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // Byte halves of the pixel word go to the two output groups
  assign pix_bytes = s_reg.pix;
  assign pixel_out_port_a = pix_bytes.hi;
  assign pixel_out_port_b = pix_bytes.lo;
  assign pclk = s_reg.pclk;
  assign de = s_reg.de;
  assign hsync_n = s_reg.hsync_n;
  assign vsync_n = s_reg.vsync_n;
  assign frame_start = s_reg.frame_start;
  assign underrun = s_reg.underrun;

endmodule

// [dv/tpd_panel_drv_asserts.sv]
// Checker for the panel driver pins.
// Bound to tpd_panel_drv; sees only its ports.
`timescale 1ns/10ps
module tpd_panel_drv_asserts
  import tpd_pkg::*;
#(
  parameter int H_ACT = H_ACTIVE
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pix_in_ready,
  input wire logic [7:0] pixel_out_port_a,
  input wire logic [7:0] pixel_out_port_b,
  input wire logic pclk,
  input wire logic de,
  input wire logic hsync_n,
  input wire logic vsync_n,
  input wire logic frame_start,
  input wire logic underrun
);
  localparam int DE_CYC = 8 * H_ACT;
  logic [15:0] de_run_reg;
  logic seen_reg;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      de_run_reg <= 16'h0000;
    else
      de_run_reg <= de ? de_run_reg + 16'h0001 : 16'h0000;
  // First line after reset may be cut short
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      seen_reg <= 1'b0;
    else
      seen_reg <= seen_reg | frame_start;
  chk_pclk_low:
    assert property ($fell(pclk) |-> !pclk [*4] ##1 pclk)
    else $error("pixel clock low phase wrong");
  chk_pclk_period:
    assert property ($fell(pclk) |-> ##8 $fell(pclk))
    else $error("pixel clock period wrong");
  chk_out_step:
    assert property ($changed({pixel_out_port_a, pixel_out_port_b, de,
      hsync_n, vsync_n}) |-> $past(pclk, 2) && !$past(pclk))
    else $error("outputs moved off the falling edge");
  chk_blank_zero:
    assert property (!de |-> {pixel_out_port_a, pixel_out_port_b} == 16'h0)
    else $error("data driven without enable");
  chk_de_syncs:
    assert property (de |-> hsync_n && vsync_n)
    else $error("enable during sync");
  chk_hsync_width:
    assert property (seen_reg && $fell(hsync_n) |-> ##64 $rose(hsync_n))
    else $error("line sync width wrong");
  chk_line_burst:
    assert property (disable iff (rst || underrun)
      $fell(de) |-> de_run_reg == DE_CYC)
    else $error("line burst length wrong");
  chk_frame_marks:
    assert property (frame_start |-> !vsync_n && !hsync_n && !de)
    else $error("frame start without syncs");
  chk_vsync_start:
    assert property ($fell(vsync_n) |-> frame_start)
    else $error("frame sync without frame start");
  cover property ($rose(de));
  cover property ($rose(underrun));
  cover property ($fell(pix_in_ready));
endmodule

bind tpd_panel_drv tpd_panel_drv_asserts #(.H_ACT(H_ACT))
  tpd_panel_drv_asserts_i (.ref_clk(ref_clk), .rst(rst),
  .pix_in_ready(pix_in_ready), .pixel_out_port_a(pixel_out_port_a),
  .pixel_out_port_b(pixel_out_port_b), .pclk(pclk), .de(de),
  .hsync_n(hsync_n), .vsync_n(vsync_n), .frame_start(frame_start),
  .underrun(underrun));

// [dv/tpd_panel_model.sv]
// Behavioural panel on the driver's output pins.
// Latches a pixel at each pixel clock rise while enable is high.
`timescale 1ns/10ps
module tpd_panel_model
  import tpd_pkg::*;
(
  input wire logic pclk,
  input wire logic de,
  input wire logic [7:0] port_a,
  input wire logic [7:0] port_b,
  output logic rx_valid,
  output tpd_rgb666_t rx_pix
);
  tpd_rgb565_t w;
  // Inputs only: the panel never drives back
  assign w = {port_a, port_b};
  always @(posedge pclk)
  begin
    rx_valid <= de;
    rx_pix <= {w.red, w.red[0], w.green, w.blue, w.blue[0]};
  end
endmodule

// [dv/tb.sv]
// Self-checking bench for the panel timing driver.
// Random pixel source on ref_clk; panel model returns received pixels.
`timescale 1ns/10ps
module tb;
  import tpd_pkg::*;
  // Slow clock counts keep a frame near 4000 cycles
  localparam int CLK = 240000;
  localparam int PIX = 30000;
  localparam int HA = 16;
  localparam int VA = 2;
  localparam int VB = 2;
  localparam int HT = PIX / (60 * (VA + VB));
  localparam int FRAME_CYC = (CLK / PIX) * HT * (VA + VB);
  `define CHK(a, b) begin checked++; if ((a) !== (b)) begin \
    fail_count++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  tpd_rgb565_t pix_in_data = 16'h0000;
  logic pix_in_valid = 1'b0;
  logic pix_in_ready, pclk, de, hsync_n, vsync_n, frame_start, underrun;
  logic [7:0] port_a, port_b;
  logic rx_valid;
  logic stall = 1'b0;
  logic [31:0] seed = 32'h0001643e;
  tpd_rgb666_t rx_pix, exp_w;
  tpd_rgb666_t exp_q[$];
  int checked = 0;
  int fail_count = 0;
  int cycles = 0;
  int pix_count = 0;
  int t0, p0;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  tpd_panel_drv #(.CLK_HZ(CLK), .PIX_HZ(PIX), .H_ACT(HA), .V_ACT(VA),
    .V_BLK(VB)) tpd_panel_drv_i (.ref_clk(ref_clk), .rst(rst),
    .pix_in_data(pix_in_data), .pix_in_valid(pix_in_valid),
    .pix_in_ready(pix_in_ready), .pixel_out_port_a(port_a),
    .pixel_out_port_b(port_b), .pclk(pclk), .de(de), .hsync_n(hsync_n),
    .vsync_n(vsync_n), .frame_start(frame_start), .underrun(underrun));
  tpd_panel_model tpd_panel_model_i (.pclk(pclk), .de(de), .port_a(port_a),
    .port_b(port_b), .rx_valid(rx_valid), .rx_pix(rx_pix));

  always #25 ref_clk = ~ref_clk;

  task automatic summarize();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wait_fs();
    int n;
    n = 0;
    @(negedge ref_clk);
    while (frame_start !== 1'b1 && n < 5000)
    begin
      @(negedge ref_clk);
      n++;
    end
    `CHK(n < 5000, 1'b1)
  endtask

  // Source: a refused word is held until taken
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      fail_count++;
      summarize();
    end
    else if (!rst)
    begin
      if (pix_in_valid && pix_in_ready === 1'b1)
        exp_q.push_back({pix_in_data.red, pix_in_data.red[0],
          pix_in_data.green, pix_in_data.blue, pix_in_data.blue[0]});
      if (!pix_in_valid || pix_in_ready === 1'b1)
      begin
        seed = xs(seed);
        pix_in_valid <= seed[0] && !stall;
        pix_in_data <= seed[31:16];
      end
    end
  end

  always @(negedge pclk)
    if (rx_valid === 1'b1)
    begin
      pix_count++;
      if (exp_q.size() == 0)
        `CHK(1'b1, 1'b0)
      else
      begin
        exp_w = exp_q.pop_front();
        `CHK(rx_pix, exp_w)
      end
    end

  initial
  begin
    repeat (10) @(posedge ref_clk);
    `CHK({port_a, port_b}, 16'h0000)
    `CHK({de, hsync_n, vsync_n, underrun, pix_in_ready}, 5'h0d)
    rst <= 1'b0;
    // Blanking line pops nothing, so the buffer fills
    repeat (20) @(negedge ref_clk);
    `CHK(pix_in_ready, 1'b0)
    `CHK({de, hsync_n, vsync_n}, 3'h3)
    wait_fs();
    t0 = cycles;
    p0 = pix_count;
    `CHK(p0, 0)
    wait_fs();
    `CHK(cycles - t0, FRAME_CYC)
    `CHK(pix_count - p0, HA * VA)
    `CHK(underrun, 1'b0)
    wait (de === 1'b1);
    @(posedge ref_clk);
    stall <= 1'b1;
    repeat (40) @(negedge ref_clk);
    `CHK(underrun, 1'b1)
    `CHK(de, 1'b0)
    @(posedge ref_clk);
    stall <= 1'b0;
    wait_fs();
    repeat (2) @(negedge ref_clk);
    `CHK(underrun, 1'b0)
    summarize();
  end
endmodule
